//--- core/upr_pkg.sv
// constants, page type and field layout for the paged register decode
// Functional notes
// - Three host address lines pick one of eight register locations per access.
// - Enhanced page is visible only while line format control holds 0xBF.
// - Location 000, divisor bit clear: read receive holding, write transmit holding.
// - Divisor bit set, not 0xBF: locations 000/001 are divisor low/high bytes.
// - Divisor page with both divisor bytes zero reads revision and identification codes.
// - Divisor bit clear: location 001 is the read/write interrupt mask.
// - Divisor bit clear: 010 reads interrupt source, writes queue control.
// - Location 011 always reaches line format control on every page.
// - Divisor bit clear: location 100 is read/write modem line control.
// - Divisor bit clear: 101 reads line state; writes extra feature when enabled.
// - Divisor bit clear: 110 reads modem line state; writes pulse width when enabled.
// - Divisor bit clear: location 111 is a scratch byte with no effect.
// - Enhanced page: 010 enhanced function, 100 to 111 resume and pause characters.
// - Extended bits act only with the enhanced enable bit set, else read zero; queue control drops them only at the write.
// - Enhanced enable bit unlocks upper bits of several registers and two registers.
package upr_pkg;

  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;

  // register locations
  localparam logic [2:0] LOC_HOLD = 3'h0;
  localparam logic [2:0] LOC_MASK = 3'h1;
  localparam logic [2:0] LOC_SRC = 3'h2;
  localparam logic [2:0] LOC_LFC = 3'h3;
  localparam logic [2:0] LOC_MLC = 3'h4;
  localparam logic [2:0] LOC_LST = 3'h5;
  localparam logic [2:0] LOC_MST = 3'h6;
  localparam logic [2:0] LOC_SCR = 3'h7;

  // page selection
  localparam logic [7:0] ENH_PAGE_CODE = 8'hBF;
  localparam int DIV_EN_BIT = 7;
  localparam int ENH_EN_BIT = 4;

  // extended bit groups gated by the enhanced enable bit, and the extra feature bits that always read zero
  localparam logic [7:0] MASK_EXT_BITS = 8'hF0;
  localparam logic [7:0] SRC_EXT_BITS = 8'h30;
  localparam logic [7:0] QCTL_EXT_BITS = 8'h30;
  localparam logic [7:0] MLC_EXT_BITS = 8'hE0;
  localparam logic [7:0] MST_EXT_BITS = 8'hF0;
  localparam logic [7:0] EXTRA_RSVD_BITS = 8'hC0;

  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] READ_NONE = 8'h00;

  typedef enum logic [1:0] {
    PAGE_BASE = 2'b00,
    PAGE_DIVISOR = 2'b01,
    PAGE_ENHANCED = 2'b10
  } upr_page_type;

endpackage

//--- core/upr_register_decode.sv
// paged register file and access control for the host side of the uart
`timescale 1ns/1ns
module upr_register_decode #(
  parameter logic [7:0] REVISION_CODE = 8'h01, // arbitrary value
  parameter logic [7:0] IDENTIFICATION_CODE = 8'h5A // arbitrary value
) (
  input wire logic clk, // 125 MHz device clock
  input wire logic rst_n, // synchronous reset, active low
  input wire logic [2:0] addr, // register location
  input wire logic wr_stb, // one-cycle write strobe
  input wire logic rd_stb, // one-cycle read strobe
  input wire logic [7:0] wr_data, // host write byte
  output logic [7:0] rd_data, // read byte, registered
  output logic rd_valid, // rd_data valid pulse
  input wire logic [7:0] receive_holding, // head of receive path
  input wire logic [7:0] interrupt_source, // live interrupt source
  input wire logic [7:0] line_state, // live line state
  input wire logic [7:0] modem_line_state, // live modem line state
  output logic [7:0] transmit_holding, // byte for transmitter
  output logic tx_load, // transmit byte pulse
  output logic rx_pop, // receive holding consumed pulse
  output logic src_read, // interrupt source read pulse
  output logic lst_read, // line state read pulse
  output logic mst_read, // modem line state read pulse
  output logic [7:0] queue_control, // last queue control write
  output logic queue_control_load, // queue control pulse
  output logic [7:0] line_format_control, // line format control
  output logic [15:0] baud_divisor, // divisor high and low bytes
  output logic [7:0] interrupt_mask, // effective interrupt mask
  output logic [7:0] modem_line_control, // effective modem line control
  output logic [7:0] enhanced_function, // enhanced function
  output logic [7:0] resume_char_one, // first resume character
  output logic [7:0] resume_char_two, // second resume character
  output logic [7:0] pause_char_one, // first pause character
  output logic [7:0] pause_char_two, // second pause character
  output logic [7:0] extra_feature, // extra feature bits
  output logic [7:0] optical_pulse_width // optical pulse width
);

  ////////////////////////////////////////////////////////////////////////////
  // stored registers

  logic [7:0] lfc_r, div_low_r, div_high_r, mask_r, mlc_r, scratch_r;
  logic [7:0] enh_fn_r, resume1_r, resume2_r, pause1_r, pause2_r, extra_r, pulse_w_r;
  logic [7:0] qctl_r, tx_byte_r, rd_data_r;
  logic qctl_load_r, tx_load_r, rd_valid_r, rx_pop_r, src_read_r, lst_read_r, mst_read_r;

  upr_pkg::upr_page_type page;
  logic enh_on;
  logic div_zero;

  // write selects
  logic wr_tx, wr_div_low, wr_div_high, wr_mask, wr_qctl, wr_lfc, wr_mlc, wr_extra;
  logic wr_pulse_w, wr_scr, wr_enh_fn, wr_resume1, wr_resume2, wr_pause1, wr_pause2;

  logic [7:0] rd_nxt;
  logic rx_pop_nxt, src_read_nxt, lst_read_nxt, mst_read_nxt;

  // clears extended bits unless the enhanced enable bit is set
  function automatic logic [7:0] gate_ext(input logic en, input logic [7:0] v,
                                          input logic [7:0] m);
    return en ? v : (v & ~m);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // page selection

  always_comb begin
    if (lfc_r == upr_pkg::ENH_PAGE_CODE) begin
      page = upr_pkg::PAGE_ENHANCED;
    end else if (lfc_r[upr_pkg::DIV_EN_BIT]) begin
      page = upr_pkg::PAGE_DIVISOR;
    end else begin
      page = upr_pkg::PAGE_BASE;
    end
  end

  assign enh_on = enh_fn_r[upr_pkg::ENH_EN_BIT];
  assign div_zero = (div_low_r == 8'h00) && (div_high_r == 8'h00);

  ////////////////////////////////////////////////////////////////////////////
  // write decode

  always_comb begin
    wr_tx = 1'b0;
    wr_div_low = 1'b0;
    wr_div_high = 1'b0;
    wr_mask = 1'b0;
    wr_qctl = 1'b0;
    wr_lfc = 1'b0;
    wr_mlc = 1'b0;
    wr_extra = 1'b0;
    wr_pulse_w = 1'b0;
    wr_scr = 1'b0;
    wr_enh_fn = 1'b0;
    wr_resume1 = 1'b0;
    wr_resume2 = 1'b0;
    wr_pause1 = 1'b0;
    wr_pause2 = 1'b0;
    if (wr_stb) begin
      if (addr == upr_pkg::LOC_LFC) begin
        wr_lfc = 1'b1;
      end else begin
        // locations not listed for a page drop the write
        case (page)
          upr_pkg::PAGE_BASE: begin
            wr_tx = (addr == upr_pkg::LOC_HOLD);
            wr_mask = (addr == upr_pkg::LOC_MASK);
            wr_qctl = (addr == upr_pkg::LOC_SRC);
            wr_mlc = (addr == upr_pkg::LOC_MLC);
            wr_extra = (addr == upr_pkg::LOC_LST) && enh_on;
            wr_pulse_w = (addr == upr_pkg::LOC_MST) && enh_on;
            wr_scr = (addr == upr_pkg::LOC_SCR);
          end
          upr_pkg::PAGE_DIVISOR: begin
            wr_div_low = (addr == upr_pkg::LOC_HOLD);
            wr_div_high = (addr == upr_pkg::LOC_MASK);
          end
          upr_pkg::PAGE_ENHANCED: begin
            wr_enh_fn = (addr == upr_pkg::LOC_SRC);
            wr_resume1 = (addr == upr_pkg::LOC_MLC);
            wr_resume2 = (addr == upr_pkg::LOC_LST);
            wr_pause1 = (addr == upr_pkg::LOC_MST);
            wr_pause2 = (addr == upr_pkg::LOC_SCR);
          end
          default: wr_scr = 1'b0;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register storage

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lfc_r <= upr_pkg::REG_RESET;
    end else if (wr_lfc) begin
      lfc_r <= wr_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      div_low_r <= upr_pkg::REG_RESET;
      div_high_r <= upr_pkg::REG_RESET;
    end else begin
      if (wr_div_low) begin
        div_low_r <= wr_data;
      end
      if (wr_div_high) begin
        div_high_r <= wr_data;
      end
    end
  end

  // extended bits are dropped at the write so that later enabling
  // cannot revive stale values
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mask_r <= upr_pkg::REG_RESET;
      mlc_r <= upr_pkg::REG_RESET;
      scratch_r <= upr_pkg::REG_RESET;
    end else begin
      if (wr_mask) begin
        mask_r <= gate_ext(enh_on, wr_data, upr_pkg::MASK_EXT_BITS);
      end
      if (wr_mlc) begin
        mlc_r <= gate_ext(enh_on, wr_data, upr_pkg::MLC_EXT_BITS);
      end
      if (wr_scr) begin
        scratch_r <= wr_data;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      enh_fn_r <= upr_pkg::REG_RESET;
      resume1_r <= upr_pkg::REG_RESET;
      resume2_r <= upr_pkg::REG_RESET;
      pause1_r <= upr_pkg::REG_RESET;
      pause2_r <= upr_pkg::REG_RESET;
    end else begin
      if (wr_enh_fn) begin
        enh_fn_r <= wr_data;
      end
      if (wr_resume1) begin
        resume1_r <= wr_data;
      end
      if (wr_resume2) begin
        resume2_r <= wr_data;
      end
      if (wr_pause1) begin
        pause1_r <= wr_data;
      end
      if (wr_pause2) begin
        pause2_r <= wr_data;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      extra_r <= upr_pkg::REG_RESET;
      pulse_w_r <= upr_pkg::REG_RESET;
    end else begin
      if (wr_extra) begin
        extra_r <= wr_data & ~upr_pkg::EXTRA_RSVD_BITS;
      end
      if (wr_pulse_w) begin
        pulse_w_r <= wr_data;
      end
    end
  end

  // write-only registers handed to the datapath with a one-cycle pulse
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tx_byte_r <= upr_pkg::REG_RESET;
      tx_load_r <= 1'b0;
      qctl_r <= upr_pkg::REG_RESET;
      qctl_load_r <= 1'b0;
    end else begin
      tx_load_r <= wr_tx;
      qctl_load_r <= wr_qctl;
      if (wr_tx) begin
        tx_byte_r <= wr_data;
      end
      if (wr_qctl) begin
        qctl_r <= gate_ext(enh_on, wr_data, upr_pkg::QCTL_EXT_BITS);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read path

  always_comb begin
    rd_nxt = upr_pkg::READ_NONE;
    rx_pop_nxt = 1'b0;
    src_read_nxt = 1'b0;
    lst_read_nxt = 1'b0;
    mst_read_nxt = 1'b0;
    if (addr == upr_pkg::LOC_LFC) begin
      rd_nxt = lfc_r;
    end else begin
      case (page)
        upr_pkg::PAGE_BASE: begin
          case (addr)
            upr_pkg::LOC_HOLD: begin
              rd_nxt = receive_holding;
              rx_pop_nxt = 1'b1;
            end
            upr_pkg::LOC_MASK: rd_nxt = interrupt_mask;
            upr_pkg::LOC_SRC: begin
              rd_nxt = gate_ext(enh_on, interrupt_source, upr_pkg::SRC_EXT_BITS);
              src_read_nxt = 1'b1;
            end
            upr_pkg::LOC_MLC: rd_nxt = modem_line_control;
            upr_pkg::LOC_LST: begin
              rd_nxt = line_state;
              lst_read_nxt = 1'b1;
            end
            upr_pkg::LOC_MST: begin
              rd_nxt = gate_ext(enh_on, modem_line_state, upr_pkg::MST_EXT_BITS);
              mst_read_nxt = 1'b1;
            end
            upr_pkg::LOC_SCR: rd_nxt = scratch_r;
            default: rd_nxt = upr_pkg::READ_NONE;
          endcase
        end
        upr_pkg::PAGE_DIVISOR: begin
          if (addr == upr_pkg::LOC_HOLD) begin
            rd_nxt = div_zero ? REVISION_CODE : div_low_r;
          end else if (addr == upr_pkg::LOC_MASK) begin
            rd_nxt = div_zero ? IDENTIFICATION_CODE : div_high_r;
          end
        end
        upr_pkg::PAGE_ENHANCED: begin
          case (addr)
            upr_pkg::LOC_SRC: rd_nxt = enh_fn_r;
            upr_pkg::LOC_MLC: rd_nxt = resume1_r;
            upr_pkg::LOC_LST: rd_nxt = resume2_r;
            upr_pkg::LOC_MST: rd_nxt = pause1_r;
            upr_pkg::LOC_SCR: rd_nxt = pause2_r;
            default: rd_nxt = upr_pkg::READ_NONE;
          endcase
        end
        default: rd_nxt = upr_pkg::READ_NONE;
      endcase
    end
  end

  // side-effect pulses line up with the data they belong to
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rd_data_r <= upr_pkg::READ_NONE;
      rd_valid_r <= 1'b0;
      rx_pop_r <= 1'b0;
      src_read_r <= 1'b0;
      lst_read_r <= 1'b0;
      mst_read_r <= 1'b0;
    end else begin
      rd_valid_r <= rd_stb;
      rx_pop_r <= rd_stb && rx_pop_nxt;
      src_read_r <= rd_stb && src_read_nxt;
      lst_read_r <= rd_stb && lst_read_nxt;
      mst_read_r <= rd_stb && mst_read_nxt;
      if (rd_stb) begin
        rd_data_r <= rd_nxt;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign rd_data = rd_data_r;
  assign rd_valid = rd_valid_r;
  assign transmit_holding = tx_byte_r;
  assign tx_load = tx_load_r;
  assign rx_pop = rx_pop_r;
  assign src_read = src_read_r;
  assign lst_read = lst_read_r;
  assign mst_read = mst_read_r;
  assign queue_control = qctl_r;
  assign queue_control_load = qctl_load_r;
  assign line_format_control = lfc_r;
  assign baud_divisor = {div_high_r, div_low_r};
  assign interrupt_mask = gate_ext(enh_on, mask_r, upr_pkg::MASK_EXT_BITS);
  assign modem_line_control = gate_ext(enh_on, mlc_r, upr_pkg::MLC_EXT_BITS);
  assign enhanced_function = enh_fn_r;
  assign resume_char_one = resume1_r;
  assign resume_char_two = resume2_r;
  assign pause_char_one = pause1_r;
  assign pause_char_two = pause2_r;
  // the two registers only act while unlocked
  assign extra_feature = enh_on ? extra_r : upr_pkg::REG_RESET;
  assign optical_pulse_width = enh_on ? pulse_w_r : upr_pkg::REG_RESET;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  read_answer_a: assert property (@(posedge clk) disable iff (!rst_n)
    rd_stb |=> rd_valid ##1 !rd_valid || $past(rd_stb))
    else $error("read strobe not answered in one cycle");
  enh_lock_a: assert property (@(posedge clk) disable iff (!rst_n)
    (wr_stb && addr == upr_pkg::LOC_SRC && lfc_r != upr_pkg::ENH_PAGE_CODE)
    |=> enhanced_function == $past(enhanced_function))
    else $error("enhanced function changed outside its page");
  tx_load_a: assert property (@(posedge clk) disable iff (!rst_n)
    (wr_stb && addr == upr_pkg::LOC_HOLD && !lfc_r[upr_pkg::DIV_EN_BIT])
    |=> tx_load && transmit_holding == $past(wr_data))
    else $error("transmit holding not loaded");
  div_write_a: assert property (@(posedge clk) disable iff (!rst_n)
    (wr_stb && addr == upr_pkg::LOC_MASK && page == upr_pkg::PAGE_DIVISOR)
    |=> baud_divisor[15:8] == $past(wr_data) && !tx_load)
    else $error("divisor high byte not written");
  rev_read_a: assert property (@(posedge clk) disable iff (!rst_n)
    (rd_stb && addr == upr_pkg::LOC_HOLD && page == upr_pkg::PAGE_DIVISOR
     && baud_divisor == 16'h0000) |=> rd_data == REVISION_CODE && !rx_pop)
    else $error("revision code not returned");
  mask_write_a: assert property (@(posedge clk) disable iff (!rst_n)
    (wr_stb && addr == upr_pkg::LOC_MASK && page == upr_pkg::PAGE_BASE && enh_on)
    |=> interrupt_mask == $past(wr_data))
    else $error("interrupt mask not written");
  src_read_a: assert property (@(posedge clk) disable iff (!rst_n)
    (rd_stb && addr == upr_pkg::LOC_SRC && page == upr_pkg::PAGE_BASE)
    |=> src_read && ((rd_data ^ $past(interrupt_source)) & ~upr_pkg::SRC_EXT_BITS) == 8'h00)
    else $error("interrupt source read wrong");
  lfc_any_page_a: assert property (@(posedge clk) disable iff (!rst_n)
    (wr_stb && addr == upr_pkg::LOC_LFC) |=> line_format_control == $past(wr_data))
    else $error("line format control not written");
  extra_write_a: assert property (@(posedge clk) disable iff (!rst_n)
    (wr_stb && addr == upr_pkg::LOC_LST && page == upr_pkg::PAGE_BASE && enh_on)
    |=> extra_feature == ($past(wr_data) & ~upr_pkg::EXTRA_RSVD_BITS))
    else $error("extra feature write wrong");
  scratch_echo_a: assert property (@(posedge clk) disable iff (!rst_n)
    (wr_stb && addr == upr_pkg::LOC_SCR && page == upr_pkg::PAGE_BASE) ##1 !wr_stb
    ##1 (rd_stb && addr == upr_pkg::LOC_SCR && page == upr_pkg::PAGE_BASE && !wr_stb)
    |=> rd_data == $past(wr_data, 3))
    else $error("scratch byte not kept");
  ext_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
    !enh_on |-> interrupt_mask[7:4] == 4'h0 && modem_line_control[7:5] == 3'h0)
    else $error("extended bits visible while locked");
  ro_write_a: assert property (@(posedge clk) disable iff (!rst_n)
    (wr_stb && addr == upr_pkg::LOC_MST && page == upr_pkg::PAGE_BASE && !enh_on)
    |=> $stable(optical_pulse_width) && $stable(scratch_r))
    else $error("read-only location accepted a write");

endmodule

//--- tb/uart_paged_register_decode_tb.sv
// self-checking bench for the paged register decode
`timescale 1ns/1ns
module uart_paged_register_decode_tb;
  localparam logic [7:0] REV_CODE = 8'h21; // arbitrary value
  localparam logic [7:0] ID_CODE = 8'h6C; // arbitrary value
  logic clk;
  logic rst_n;
  logic [2:0] addr;
  logic wr_stb;
  logic rd_stb;
  logic [7:0] wr_data;
  logic [7:0] rd_data;
  logic rd_valid;
  logic [7:0] rx_head;
  logic [7:0] src_in;
  logic [7:0] lst_in;
  logic [7:0] mst_in;
  logic [7:0] tx_byte;
  logic [7:0] qctl;
  logic [7:0] lfc;
  logic [15:0] divisor;
  logic [7:0] imask;
  logic [7:0] mlc;
  logic [7:0] enh_fn;
  logic [7:0] res1;
  logic [7:0] res2;
  logic [7:0] pse1;
  logic [7:0] pse2;
  logic tx_pulse;
  logic rx_pulse;
  logic src_pulse;
  logic lst_pulse;
  logic mst_pulse;
  logic qctl_pulse;
  logic [7:0] xfeat;
  logic [7:0] pwidth;
  int failures;
  int checked;

  upr_host_model host_u (.clk(clk), .addr(addr), .wr_stb(wr_stb), .rd_stb(rd_stb),
    .wr_data(wr_data), .rd_data(rd_data), .rd_valid(rd_valid));

  upr_register_decode #(.REVISION_CODE(REV_CODE), .IDENTIFICATION_CODE(ID_CODE)) dut_u (
    .clk(clk), .rst_n(rst_n), .addr(addr), .wr_stb(wr_stb), .rd_stb(rd_stb),
    .wr_data(wr_data), .rd_data(rd_data), .rd_valid(rd_valid),
    .receive_holding(rx_head), .interrupt_source(src_in), .line_state(lst_in),
    .modem_line_state(mst_in), .transmit_holding(tx_byte), .tx_load(tx_pulse),
    .rx_pop(rx_pulse), .src_read(src_pulse), .lst_read(lst_pulse), .mst_read(mst_pulse),
    .queue_control(qctl), .queue_control_load(qctl_pulse),
    .line_format_control(lfc), .baud_divisor(divisor), .interrupt_mask(imask),
    .modem_line_control(mlc), .enhanced_function(enh_fn), .resume_char_one(res1),
    .resume_char_two(res2), .pause_char_one(pse1), .pause_char_two(pse2),
    .extra_feature(xfeat), .optical_pulse_width(pwidth));

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic finish_test;
    $display("comparisons %0d, mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask

  task automatic rdc(input logic [2:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic v;
    host_u.rd(a, d, v);
    chk("rd_valid", 8'h01, {7'h00, v});
    chk($sformatf("read of location %0d", a), exp, d);
  endtask

  // pulses stand one cycle, so they are looked at right after the access
  task automatic pls(input string name, input logic exp, input logic got);
    chk(name, {7'h00, exp}, {7'h00, got});
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // each access takes two cycles, so this span is ample
  initial begin
    repeat (5000) @(posedge clk);
    failures++;
    finish_test();
  end

  initial begin
    rst_n = 1'b0;
    rx_head = 8'hA5;
    src_in = 8'hFF;
    lst_in = 8'h3C;
    mst_in = 8'hFF;
    failures = 0;
    checked = 0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    // base page with the enhanced bits still locked
    rdc(3'h3, 8'h00);
    host_u.wr(3'h0, 8'h5A);
    chk("transmit_holding", 8'h5A, tx_byte);
    pls("tx_load", 1'b1, tx_pulse);
    rdc(3'h0, 8'hA5);
    pls("rx_pop", 1'b1, rx_pulse);
    host_u.wr(3'h1, 8'hFF);
    rdc(3'h1, 8'h0F);
    chk("interrupt_mask", 8'h0F, imask);
    rdc(3'h2, 8'hCF);
    pls("src_read", 1'b1, src_pulse);
    host_u.wr(3'h2, 8'hFF);
    chk("queue_control", 8'hCF, qctl);
    pls("queue_control_load", 1'b1, qctl_pulse);
    host_u.wr(3'h4, 8'hFF);
    rdc(3'h4, 8'h1F);
    chk("modem_line_control", 8'h1F, mlc);
    rdc(3'h5, 8'h3C);
    pls("lst_read", 1'b1, lst_pulse);
    host_u.wr(3'h5, 8'h3F);
    chk("extra_feature", 8'h00, xfeat);
    rdc(3'h6, 8'h0F);
    pls("mst_read", 1'b1, mst_pulse);
    host_u.wr(3'h6, 8'h77);
    chk("optical_pulse_width", 8'h00, pwidth);
    host_u.wr(3'h7, 8'hC3);
    rdc(3'h7, 8'hC3);
    // divisor overlay: identity codes while both bytes are zero
    host_u.wr(3'h3, 8'h80);
    rdc(3'h0, REV_CODE);
    pls("rx_pop", 1'b0, rx_pulse);
    rdc(3'h1, ID_CODE);
    host_u.wr(3'h0, 8'h12);
    pls("tx_load", 1'b0, tx_pulse);
    host_u.wr(3'h1, 8'h34);
    rdc(3'h0, 8'h12);
    rdc(3'h1, 8'h34);
    chk("baud_divisor high", 8'h34, divisor[15:8]);
    chk("baud_divisor low", 8'h12, divisor[7:0]);
    rdc(3'h3, 8'h80);
    host_u.wr(3'h7, 8'h99);
    rdc(3'h7, 8'h00);
    // enhanced page
    host_u.wr(3'h3, 8'hBF);
    host_u.wr(3'h2, 8'h10);
    pls("queue_control_load", 1'b0, qctl_pulse);
    rdc(3'h2, 8'h10);
    chk("enhanced_function", 8'h10, enh_fn);
    for (int i = 0; i < 4; i++) begin
      host_u.wr(3'h4 + 3'(i), 8'h41 + 8'(i));
    end
    for (int i = 0; i < 4; i++) begin
      rdc(3'h4 + 3'(i), 8'h41 + 8'(i));
    end
    chk("resume_char_one", 8'h41, res1);
    chk("resume_char_two", 8'h42, res2);
    chk("pause_char_one", 8'h43, pse1);
    chk("pause_char_two", 8'h44, pse2);
    rdc(3'h3, 8'hBF);
    host_u.wr(3'h0, 8'h99);
    chk("baud_divisor low", 8'h12, divisor[7:0]);
    rdc(3'h0, 8'h00);
    // back to the base page with the enhanced bits unlocked
    host_u.wr(3'h3, 8'h03);
    chk("line_format_control", 8'h03, lfc);
    rdc(3'h7, 8'hC3);
    rdc(3'h1, 8'h0F);
    host_u.wr(3'h1, 8'hFF);
    rdc(3'h1, 8'hFF);
    rdc(3'h2, 8'hFF);
    host_u.wr(3'h2, 8'hFF);
    chk("queue_control", 8'hFF, qctl);
    host_u.wr(3'h4, 8'hFF);
    rdc(3'h4, 8'hFF);
    chk("modem_line_control", 8'hFF, mlc);
    rdc(3'h6, 8'hFF);
    host_u.wr(3'h5, 8'hFF);
    chk("extra_feature", 8'h3F, xfeat);
    rdc(3'h5, 8'h3C);
    host_u.wr(3'h6, 8'h77);
    chk("optical_pulse_width", 8'h77, pwidth);
    host_u.wr(3'h0, 8'hE1);
    chk("transmit_holding", 8'hE1, tx_byte);
    chk("baud_divisor low", 8'h12, divisor[7:0]);
    finish_test();
  end
endmodule

//--- tb/upr_host_model.sv
// host processor model driving the byte-wide register bus
`timescale 1ns/1ns
module upr_host_model (
  input wire logic clk, // device clock
  output logic [2:0] addr, // register location
  output logic wr_stb, // write request
  output logic rd_stb, // read request
  output logic [7:0] wr_data, // write byte
  input wire logic [7:0] rd_data, // read byte
  input wire logic rd_valid // read answer flag
);
  initial begin
    addr = 3'h0;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    wr_data = 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // one access per call: launched after an edge, taken at the next one
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wr_data <= d;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
    // released lines show the inverse so a stale value cannot pass as live
    addr <= ~a;
    wr_data <= ~d;
    #1;
  endtask

  // the answer stands one cycle only, so it is taken just after the edge
  task automatic rd(input logic [2:0] a, output logic [7:0] d, output logic v);
    @(posedge clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    addr <= ~a;
    #1;
    v = rd_valid;
    d = rd_data;
  endtask
endmodule
